// *** core/csce_pkg.sv ***
package csce_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses in the controller register space)
	// ----------------------------------------------------------------
	localparam logic [7:0] CSCE_ADDR_EVENT   = 8'h30;
	localparam logic [7:0] CSCE_ADDR_MASK    = 8'h34;
	localparam logic [7:0] CSCE_ADDR_PRESENT = 8'h38;
	localparam logic [7:0] CSCE_ADDR_FORCE   = 8'h3C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CSCE_BIT_INTERRUPT_FLAG     = 15;
	localparam int CSCE_BIT_WAKE     = 14;
	localparam int CSCE_BIT_GENERAL_WAKE    = 4;
	localparam int CSCE_AUDIO_HI     = 6;
	localparam int CSCE_AUDIO_LO     = 5;

	// ----------------------------------------------------------------
	// reset values and widths
	// ----------------------------------------------------------------
	localparam int          CSCE_DATA_W      = 32;
	localparam int          CSCE_SYNC_STAGES = 3;
	localparam logic [31:0] CSCE_RST_WORD    = 32'h0000_0000;
	localparam logic [1:0]  CSCE_AUDIO_RST   = 2'h0;
	localparam logic        CSCE_RST_BIT     = 1'h0;

endpackage

// *** core/csce_pin_sync.sv ***
`timescale 1ns/1ps
module csce_pin_sync (
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic ce_in,
	input  wire logic pin_in,
	output logic      level_out
);

	logic [csce_pkg::CSCE_SYNC_STAGES-1:0] stage_reg;

	// ----------------------------------------------------------------
	// three stages, change accepted when the last two agree
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			stage_reg <= '0;
		end else if (ce_in) begin
			stage_reg <= {stage_reg[1:0], pin_in};
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			level_out <= csce_pkg::CSCE_RST_BIT;
		end else if (ce_in && (stage_reg[1] == stage_reg[2])) begin
			level_out <= stage_reg[2];
		end
	end

endmodule // csce_pin_sync

// *** core/csce_status_change.sv ***
// Contract
// - mask bit 15 low blocks interrupt line
// - interrupt needs mask bit and control-block enable
// - mask bit 14 low blocks status-change output unless PME enable is set
// - bit 14 acts only with bit 4
// - mask bit 4 low blocks wake events at status-change output unless PME enable is set
// - status-change needs 14 and 4, or PME enable
// - audio pulse field stays zero
// - present bit 15 follows live pending interrupt
// - present bit 4 ORs three gated wake flags
// - each wake flag gated by its own setting
// - force bit 15 sets interrupt flag
// - force bit 4 sets general wake flag
// - reserved bits read zero after reset
// - event bit 15 set by source, write-one clears
// - event bit 4 and PME status clear together
// - reset initialises; no access in PCI mode
`timescale 1ns/1ps
module csce_status_change (
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        ce_in,
	input  wire logic        cardbus_mode_in,
	input  wire logic [7:0]  csr_addr_in,
	input  wire logic        csr_wr_in,
	input  wire logic        csr_rd_in,
	input  wire logic [31:0] csr_wdata_in,
	output logic [31:0]      csr_rdata_out,
	output logic             csr_rvalid_out,
	input  wire logic        interrupt_flag_pending_in,
	input  wire logic        system_control_block_int_en_in,
	input  wire logic        link_change_in,
	input  wire logic        magic_frame_in,
	input  wire logic        interesting_frame_in,
	input  wire logic        link_wake_en_in,
	input  wire logic        magic_wake_dis_in,
	input  wire logic        filter_en_in,
	input  wire logic        pme_enable_in,
	input  wire logic        pme_status_clear_in,
	output logic             pme_status_clear_out,
	output logic             inta_n_out,
	output logic             cstschg_out
);

	logic        cardbus_mode;
	logic        access_ok;
	logic        wr_event;
	logic        wr_mask;
	logic        wr_force;
	logic        rd_hit;
	logic        wake_source;
	logic        interrupt_flag_mask_reg;
	logic        wake_mask_reg;
	logic        general_wake_mask_reg;
	logic [1:0]  audio_pulse_enable_reg;
	logic        interrupt_flag_reg;
	logic        general_wake_reg;
	logic [31:0] rdata_next;

	// ----------------------------------------------------------------
	// mode pin and access decode
	// ----------------------------------------------------------------
	csce_pin_sync u_mode_sync (
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.ce_in     (ce_in),
		.pin_in    (cardbus_mode_in),
		.level_out (cardbus_mode)
	);

	assign access_ok = ce_in && cardbus_mode;
	assign wr_event  = access_ok && csr_wr_in && (csr_addr_in == csce_pkg::CSCE_ADDR_EVENT);
	assign wr_mask   = access_ok && csr_wr_in && (csr_addr_in == csce_pkg::CSCE_ADDR_MASK);
	assign wr_force  = access_ok && csr_wr_in && (csr_addr_in == csce_pkg::CSCE_ADDR_FORCE);
	assign rd_hit    = access_ok && csr_rd_in;

	// ----------------------------------------------------------------
	// gated wake source
	// ----------------------------------------------------------------
	assign wake_source = (link_change_in && link_wake_en_in)
		|| (magic_frame_in && !magic_wake_dis_in)
		|| (interesting_frame_in && filter_en_in);

	// ----------------------------------------------------------------
	// mask register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			interrupt_flag_mask_reg  <= csce_pkg::CSCE_RST_BIT;
			wake_mask_reg  <= csce_pkg::CSCE_RST_BIT;
			general_wake_mask_reg <= csce_pkg::CSCE_RST_BIT;
		end else if (wr_mask) begin
			interrupt_flag_mask_reg  <= csr_wdata_in[csce_pkg::CSCE_BIT_INTERRUPT_FLAG];
			wake_mask_reg  <= csr_wdata_in[csce_pkg::CSCE_BIT_WAKE];
			general_wake_mask_reg <= csr_wdata_in[csce_pkg::CSCE_BIT_GENERAL_WAKE];
		end
	end

	// audio pulse field has no use here, held at its default
	always_ff @(posedge clk_in) begin
		audio_pulse_enable_reg <= csce_pkg::CSCE_AUDIO_RST;
	end

	// ----------------------------------------------------------------
	// event flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			interrupt_flag_reg <= csce_pkg::CSCE_RST_BIT;
		end else if (ce_in) begin
			if (interrupt_flag_pending_in) begin
				interrupt_flag_reg <= 1'h1;
			end else if (wr_force && csr_wdata_in[csce_pkg::CSCE_BIT_INTERRUPT_FLAG]) begin
				interrupt_flag_reg <= 1'h1;
			end else if (wr_event && csr_wdata_in[csce_pkg::CSCE_BIT_INTERRUPT_FLAG]) begin
				interrupt_flag_reg <= 1'h0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			general_wake_reg <= csce_pkg::CSCE_RST_BIT;
		end else if (ce_in) begin
			if (wake_source) begin
				general_wake_reg <= 1'h1;
			end else if (wr_force && csr_wdata_in[csce_pkg::CSCE_BIT_GENERAL_WAKE]) begin
				general_wake_reg <= 1'h1;
			end else if ((wr_event && csr_wdata_in[csce_pkg::CSCE_BIT_GENERAL_WAKE])
				|| pme_status_clear_in) begin
				general_wake_reg <= 1'h0;
			end
		end
	end

	// clears the PME status bit alongside event bit 4
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			pme_status_clear_out <= csce_pkg::CSCE_RST_BIT;
		end else if (ce_in) begin
			pme_status_clear_out <= wr_event && csr_wdata_in[csce_pkg::CSCE_BIT_GENERAL_WAKE];
		end
	end

	// ----------------------------------------------------------------
	// outputs toward the host
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			inta_n_out <= 1'h1;
		end else if (ce_in) begin
			inta_n_out <= !(interrupt_flag_reg && interrupt_flag_mask_reg
				&& system_control_block_int_en_in);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			cstschg_out <= csce_pkg::CSCE_RST_BIT;
		end else if (ce_in) begin
			cstschg_out <= general_wake_reg
				&& ((wake_mask_reg && general_wake_mask_reg) || pme_enable_in);
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_comb begin
		rdata_next = csce_pkg::CSCE_RST_WORD;
		unique case (csr_addr_in)
			csce_pkg::CSCE_ADDR_EVENT: begin
				rdata_next[csce_pkg::CSCE_BIT_INTERRUPT_FLAG]  = interrupt_flag_reg;
				rdata_next[csce_pkg::CSCE_BIT_GENERAL_WAKE] = general_wake_reg;
			end
			csce_pkg::CSCE_ADDR_MASK: begin
				rdata_next[csce_pkg::CSCE_BIT_INTERRUPT_FLAG]  = interrupt_flag_mask_reg;
				rdata_next[csce_pkg::CSCE_BIT_WAKE]  = wake_mask_reg;
				rdata_next[csce_pkg::CSCE_AUDIO_HI:csce_pkg::CSCE_AUDIO_LO] =
					audio_pulse_enable_reg;
				rdata_next[csce_pkg::CSCE_BIT_GENERAL_WAKE] = general_wake_mask_reg;
			end
			csce_pkg::CSCE_ADDR_PRESENT: begin
				rdata_next[csce_pkg::CSCE_BIT_INTERRUPT_FLAG]  = interrupt_flag_pending_in;
				rdata_next[csce_pkg::CSCE_BIT_GENERAL_WAKE] = wake_source;
			end
			default: begin
				rdata_next = csce_pkg::CSCE_RST_WORD;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			csr_rdata_out  <= csce_pkg::CSCE_RST_WORD;
			csr_rvalid_out <= csce_pkg::CSCE_RST_BIT;
		end else if (ce_in) begin
			csr_rvalid_out <= csr_rd_in;
			csr_rdata_out  <= rd_hit ? rdata_next : csce_pkg::CSCE_RST_WORD;
		end
	end

endmodule // csce_status_change

// *** tb/csce_status_change_checker.sv ***
`timescale 1ns/1ps
module csce_status_change_checker (
	input wire logic		clk_in,
	input wire logic		rstn_in,
	input wire logic		csr_rd_in,
	input wire logic		csr_wr_in,
	input wire logic		csr_rvalid_out,
	input wire logic [31:0]	csr_rdata_out,
	input wire logic		interrupt_flag_pending_in,
	input wire logic		system_control_block_int_en_in,
	input wire logic		pme_status_clear_out,
	input wire logic		inta_n_out,
	input wire logic		cstschg_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	a_rd_answer: assert property (csr_rvalid_out == $past(csr_rd_in))
		else $error("read answer late");
	a_idle_rdata: assert property (!csr_rvalid_out |-> csr_rdata_out == 32'h0)
		else $error("idle read data");
	a_reserved_zero: assert property (csr_rvalid_out |-> (csr_rdata_out & 32'hFFFF_3FEF) == 32'h0)
		else $error("reserved bits set");
	a_audio_zero: assert property (csr_rvalid_out |-> csr_rdata_out[6:5] == 2'h0)
		else $error("audio field set");
	a_int_gated: assert property (!system_control_block_int_en_in |=> inta_n_out)
		else $error("line without enable");
	a_int_kept: assert property (interrupt_flag_pending_in && system_control_block_int_en_in && !inta_n_out
		&& !$past(csr_wr_in) |=> !inta_n_out)
		else $error("line dropped while pending");
	a_pme_single: assert property (pme_status_clear_out |=> !pme_status_clear_out)
		else $error("pme clear too long");
	a_pme_cause: assert property (pme_status_clear_out |-> $past(csr_wr_in))
		else $error("pme clear without write");
	cover property (!inta_n_out);
	cover property (cstschg_out);
	cover property (pme_status_clear_out);
endmodule // csce_status_change_checker

// *** tb/csce_host_model.sv ***
`timescale 1ns/1ps
module csce_host_model (
	input wire logic		clk_in,
	input wire logic [31:0]	csr_rdata_out,
	input wire logic		csr_rvalid_out,
	output logic [7:0]		csr_addr_in,
	output logic			csr_wr_in,
	output logic			csr_rd_in,
	output logic [31:0]		csr_wdata_in
);
	initial {csr_addr_in, csr_wr_in, csr_rd_in, csr_wdata_in} = '0;
	// whole words, one strobe per cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_in);
		{csr_addr_in, csr_wdata_in, csr_wr_in} = {a, d, 1'b1};
		@(negedge clk_in);
		csr_wr_in = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clk_in);
		{csr_addr_in, csr_rd_in} = {a, 1'b1};
		@(negedge clk_in);
		csr_rd_in = 1'b0;
		d = csr_rdata_out;
	endtask
endmodule // csce_host_model

// *** tb/cardbus_status_change_events_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("[FAIL] %0t got %h exp %h", $time, g, e); \
	end \
end
module cardbus_status_change_events_test;
	localparam logic [7:0] EV = csce_pkg::CSCE_ADDR_EVENT;
	localparam logic [7:0] MK = csce_pkg::CSCE_ADDR_MASK;
	localparam logic [7:0] PS = csce_pkg::CSCE_ADDR_PRESENT;
	localparam logic [7:0] FE = csce_pkg::CSCE_ADDR_FORCE;
	localparam logic [7:0] AD [5] = '{EV, MK, PS, FE, 8'h40};
	localparam logic [31:0] WM [3] = '{32'h10, 32'h4000, 32'h0};
	localparam logic [6:0] WK [7] = '{7'h20, 7'h64, 7'h12, 7'h50, 7'h08, 7'h49, 7'h07};
	logic			clk_in = 1'b0;
	logic			rstn_in = 1'b0;
	logic			ce_in = 1'b1;
	logic			cardbus_mode_in = 1'b1;
	logic			interrupt_flag_pending_in, system_control_block_int_en_in, pme_enable_in;
	logic			pme_status_clear_in, link_change_in, magic_frame_in;
	logic			interesting_frame_in, link_wake_en_in, magic_wake_dis_in, filter_en_in;
	logic [7:0]		csr_addr_in;
	logic [31:0]	csr_wdata_in, csr_rdata_out, rv;
	logic			csr_wr_in, csr_rd_in, csr_rvalid_out, pme_status_clear_out;
	logic			inta_n_out, cstschg_out;
	int				err_count = 0;
	int				checks_done = 0;
	int				cycles = 0;
	always #10 clk_in = ~clk_in;
	csce_status_change csce_status_change_i (.*);
	csce_host_model csce_host_model_i (.*);
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			wrap_up();
		end
	end
	task automatic step(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		csce_host_model_i.wr(a, d);
	endtask
	task automatic ck_rd(input logic [7:0] a, input logic [31:0] e);
		csce_host_model_i.rd(a, rv);
		`CHK(rv, e)
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		foreach (AD[i]) ck_rd(AD[i], 32'h0);
		wr(MK, 32'hFFFF_FFFF);
		wr(PS, 32'hFFFF_FFFF);
		ck_rd(MK, 32'h0000_C010);
		ck_rd(PS, 32'h0);
	endtask
	task automatic t_interrupt_flag;
		wr(MK, 32'h8000);
		{interrupt_flag_pending_in, system_control_block_int_en_in} = 2'b11;
		ck_rd(PS, 32'h8000);
		`CHK(inta_n_out, 1'b0)
		wr(EV, 32'h8000);
		ck_rd(EV, 32'h8000);
		{interrupt_flag_pending_in, system_control_block_int_en_in} = 2'b00;
		step(2);
		`CHK(inta_n_out, 1'b1)
		ck_rd(PS, 32'h0);
		system_control_block_int_en_in = 1'b1;
		wr(MK, 32'h0);
		step(1);
		`CHK(inta_n_out, 1'b1)
		ck_rd(EV, 32'h8000);
	endtask
	task automatic t_force;
		wr(MK, 32'hC010);
		wr(EV, 32'h8000);
		wr(FE, 32'h0);
		ck_rd(EV, 32'h0);
		wr(FE, 32'h8010);
		ck_rd(EV, 32'h8010);
		`CHK({inta_n_out, cstschg_out}, 2'b01)
		foreach (WM[i]) begin
			wr(MK, WM[i]);
			step(1);
			`CHK(cstschg_out, 1'b0)
		end
		pme_enable_in = 1'b1;
		step(2);
		`CHK(cstschg_out, 1'b1)
		pme_enable_in = 1'b0;
		wr(EV, 32'h10);
		`CHK(pme_status_clear_out, 1'b1)
		ck_rd(EV, 32'h8000);
		wr(FE, 32'h10);
		pme_status_clear_in = 1'b1;
		step(1);
		pme_status_clear_in = 1'b0;
		ck_rd(EV, 32'h8000);
		wr(EV, 32'h8000);
	endtask
	task automatic t_wake;
		foreach (WK[i]) begin
			{link_change_in, magic_frame_in, interesting_frame_in,
				link_wake_en_in, magic_wake_dis_in, filter_en_in} = WK[i][5:0];
			ck_rd(PS, {27'h0, WK[i][6], 4'h0});
		end
		ck_rd(EV, 32'h10);
		wr(EV, 32'h10);
		ck_rd(EV, 32'h0);
	endtask
	task automatic t_pci;
		wr(MK, 32'h8000);
		cardbus_mode_in = 1'b0;
		step(4);
		wr(MK, 32'h4010);
		ck_rd(MK, 32'h0);
		cardbus_mode_in = 1'b1;
		step(4);
		ck_rd(MK, 32'h8000);
		rstn_in = 1'b0;
		step(3);
		rstn_in = 1'b1;
		step(4);
		ck_rd(MK, 32'h0);
	endtask
	initial begin
		{interrupt_flag_pending_in, system_control_block_int_en_in, pme_enable_in} = '0;
		{pme_status_clear_in, link_change_in, magic_frame_in, interesting_frame_in} = '0;
		{link_wake_en_in, magic_wake_dis_in, filter_en_in} = '0;
		step(4);
		rstn_in = 1'b1;
		step(4);
		t_regs();
		t_interrupt_flag();
		t_force();
		t_wake();
		t_pci();
		wrap_up();
	end
endmodule // cardbus_status_change_events_test
bind csce_status_change csce_status_change_checker csce_status_change_checker_i (.*);
